// File: rtl/ebac_regs.vh
// Register offsets, field positions and reset values of the external
// bus area configuration block.
// Assumes a 16-bit register address from the CPU-side register port.
`ifndef EBAC_REGS_VH
`define EBAC_REGS_VH

`define EBAC_ADDR_W           16
`define EBAC_OFF_BUS_WIDTH    16'hFED0
`define EBAC_OFF_ACC_STATE    16'hFED1
`define EBAC_OFF_WAIT_HIGH    16'hFED2
`define EBAC_OFF_WAIT_LOW     16'hFED3
`define EBAC_RST_WIDTH_8BIT   8'hFF
`define EBAC_RST_WIDTH_16BIT  8'h00
`define EBAC_RST_ACC_STATE    8'hFF
`define EBAC_RST_WAIT         8'hFF
`define EBAC_MODE_16BIT       3'h4
// Wait field of area n sits at bits 2*(n%4)+1 : 2*(n%4)
`define EBAC_WAIT_FIELD_W     2
`define EBAC_AREAS_PER_WAIT_REG 4

`endif

// File: rtl/ebac_area_timing.v
// One area's access timing decode from its width, state and wait bits.
// Assumes configuration bits come from registers on the same clock.
`timescale 1ns/10ps

module ebac_area_timing (
  input  wire       i_width_sel,
  input  wire       i_state_sel,
  input  wire [1:0] i_wait_sel,
  output wire       o_is_8bit,
  output wire [2:0] o_states,
  output wire [1:0] o_waits,
  output wire       o_wait_pin_en
);

  // Bit 1 means byte-wide space, 0 means word-wide
  assign o_is_8bit = i_width_sel;
  // Two-state areas take two states, three-state areas three
  assign o_states = i_state_sel ? 3'h3 : 3'h2;
  // Program waits only count in three-state areas
  assign o_waits = i_state_sel ? i_wait_sel : 2'h0;
  // External wait insertion follows the state bit
  assign o_wait_pin_en = i_state_sel;

endmodule

// File: rtl/ebac_top.v
// What this block does
// - Width bit 0 means 16-bit area access; bit 1 means 8-bit.
// - Reset width bits to all ones in modes 5-7, zeros in mode 4.
// - State bit 0: two-state access, no wait insertion.
// - State bit 1: three-state access, wait insertion allowed.
// - All eight state bits reset to one and are read/write.
// - Two-bit wait field gives zero to three program wait states.
//
// Holds the four area configuration registers and decodes per-area
// timing for the external bus sequencer. Assumes i_mode is a strap
// that is stable around reset release.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
`include "ebac_regs.vh"

module ebac_top #(
  parameter NUM_AREAS = 8
) (
  input  wire                      i_core_clk,
  input  wire                      i_rst_n,
  input  wire [2:0]                i_mode,
  input  wire [`EBAC_ADDR_W-1:0]   i_addr,
  input  wire [7:0]                i_wdata,
  input  wire                      i_wr,
  input  wire                      i_rd,
  output reg  [7:0]                o_rdata,
  output wire [NUM_AREAS-1:0]      o_area_8bit,
  output wire [NUM_AREAS*3-1:0]    o_area_states,
  output wire [NUM_AREAS*2-1:0]    o_area_waits,
  output wire [NUM_AREAS-1:0]      o_area_wait_pin_en
);

  reg  [7:0] bus_width_q;
  reg  [7:0] acc_state_q;
  reg  [7:0] wait_high_q;
  reg  [7:0] wait_low_q;
  reg        mode_sync1_q;
  reg        mode_sync2_q;
  reg  [2:0] mode0_s1_q;
  reg  [2:0] mode_cap_q;
  reg        strap_done_q;
  reg  [7:0] rdata_d;
  wire       hit_width;
  wire       hit_state;
  wire       hit_wh;
  wire       hit_wl;

  // Strap pin is from outside the clock domain: two flops first
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode0_s1_q <= 3'h0;
      mode_cap_q <= 3'h0;
    end else begin
      mode0_s1_q <= i_mode;
      mode_cap_q <= mode0_s1_q;
    end
  end

  // Strap applied once, at the third edge after release, so async reset
  // loads only constants; a width write on that edge still wins
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_sync1_q <= 1'h0;
      mode_sync2_q <= 1'h0;
      strap_done_q <= 1'h0;
    end else begin
      mode_sync1_q <= 1'h1;
      mode_sync2_q <= mode_sync1_q;
      strap_done_q <= mode_sync2_q;
    end
  end

  assign hit_width = (i_addr == `EBAC_OFF_BUS_WIDTH);
  assign hit_state = (i_addr == `EBAC_OFF_ACC_STATE);
  assign hit_wh    = (i_addr == `EBAC_OFF_WAIT_HIGH);
  assign hit_wl    = (i_addr == `EBAC_OFF_WAIT_LOW);

  // Register writes; width reset value depends on the mode strap
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus_width_q <= `EBAC_RST_WIDTH_8BIT;
      acc_state_q <= `EBAC_RST_ACC_STATE;
      wait_high_q <= `EBAC_RST_WAIT;
      wait_low_q  <= `EBAC_RST_WAIT;
    end else begin
      if (i_wr && hit_width) begin
        bus_width_q <= i_wdata;
      end else if (mode_sync2_q && !strap_done_q) begin
        // Mode 4 gives word areas, other modes byte areas
        if (mode_cap_q == `EBAC_MODE_16BIT) begin
          bus_width_q <= `EBAC_RST_WIDTH_16BIT;
        end else begin
          bus_width_q <= `EBAC_RST_WIDTH_8BIT;
        end
      end
      if (i_wr && hit_state) begin
        acc_state_q <= i_wdata;
      end
      if (i_wr && hit_wh) begin
        wait_high_q <= i_wdata;
      end
      if (i_wr && hit_wl) begin
        wait_low_q <= i_wdata;
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    rdata_d = 8'h00;
    if (hit_width) begin
      rdata_d = bus_width_q;
    end else if (hit_state) begin
      rdata_d = acc_state_q;
    end else if (hit_wh) begin
      rdata_d = wait_high_q;
    end else if (hit_wl) begin
      rdata_d = wait_low_q;
    end
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rdata_d;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // Per-area timing decode; areas 7..4 in the high wait register
  genvar g;
  generate
    for (g = 0; g < NUM_AREAS; g = g + 1) begin : g_area
      localparam integer FIELD_LSB =
        (g % `EBAC_AREAS_PER_WAIT_REG) * `EBAC_WAIT_FIELD_W;
      wire [7:0] wait_reg;
      assign wait_reg = (g >= `EBAC_AREAS_PER_WAIT_REG) ? wait_high_q
                                                        : wait_low_q;
      ebac_area_timing u_timing (
        .i_width_sel   (bus_width_q[g]),
        .i_state_sel   (acc_state_q[g]),
        .i_wait_sel    (wait_reg[FIELD_LSB +: `EBAC_WAIT_FIELD_W]),
        .o_is_8bit     (o_area_8bit[g]),
        .o_states      (o_area_states[g*3 +: 3]),
        .o_waits       (o_area_waits[g*2 +: 2]),
        .o_wait_pin_en (o_area_wait_pin_en[g])
      );
    end
  endgenerate

endmodule

// File: verification/ebac_mem_model.sv
// Far-side memory model: bus hold time of one area in clocks.
// Assumes that area's state and wait fields from ebac_top.
`timescale 1ns/10ps
module ebac_mem_model (
  input  wire logic [2:0] i_states,
  input  wire logic [1:0] i_waits,
  output logic      [3:0] o_cycles
);
  // Memory holds the bus for the base states plus program waits
  assign o_cycles = {1'b0, i_states} + {2'b00, i_waits};
endmodule

// File: verification/ebac_top_assertions.sv
// Port assertions of the area configuration block.
// Assumes a bind to ebac_top with eight areas.
`timescale 1ns/10ps
module ebac_top_assertions #(parameter NUM_AREAS = 8) (
  input wire        i_core_clk,
  input wire        i_rst_n,
  input wire [2:0]  i_mode,
  input wire [15:0] i_addr,
  input wire [7:0]  i_wdata,
  input wire        i_wr,
  input wire        i_rd,
  input wire [7:0]  o_rdata,
  input wire [7:0]  o_area_8bit,
  input wire [23:0] o_area_states,
  input wire [15:0] o_area_waits,
  input wire [7:0]  o_area_wait_pin_en
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // Strobes taken at the edge where they are high
  sequence s_wr(a);
    i_wr && i_addr == a;
  endsequence
  sequence s_rd(a);
    i_rd && i_addr == a;
  endsequence
  chk_width_wr: assert property (s_wr(16'hFED0) |=>
    o_area_8bit == $past(i_wdata)) else $error("width write lost");
  chk_state_wr: assert property (s_wr(16'hFED1) |=>
    o_area_wait_pin_en == $past(i_wdata)) else $error("state write lost");
  chk_two_state: assert property (!o_area_wait_pin_en[4] |->
    o_area_states[14:12] == 3'h2 && o_area_waits[9:8] == 2'h0)
    else $error("two-state decode wrong");
  chk_three_state: assert property (o_area_wait_pin_en[0] |->
    o_area_states[2:0] == 3'h3) else $error("three-state decode wrong");
  chk_state_read: assert property (s_rd(16'hFED1) |=>
    o_rdata == $past(o_area_wait_pin_en)) else $error("state read wrong");
  chk_wait_area7: assert property (s_wr(16'hFED2) ##1
    o_area_wait_pin_en[7] |-> o_area_waits[15:14] == $past(i_wdata[7:6]))
    else $error("area 7 waits wrong");
  chk_wait_area3: assert property (s_wr(16'hFED3) ##1
    o_area_wait_pin_en[3] |-> o_area_waits[7:6] == $past(i_wdata[7:6]))
    else $error("area 3 waits wrong");
  chk_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data outside its slot");
  chk_reset_state: assert property ($rose(i_rst_n) |->
    o_area_wait_pin_en == 8'hFF) else $error("state reset wrong");
  chk_mode_width: assert property ($rose(i_rst_n) |-> ##3
    o_area_8bit == (i_mode == 3'h4 ? 8'h00 : 8'hFF))
    else $error("mode width load wrong");
endmodule
bind ebac_top ebac_top_assertions #(.NUM_AREAS(NUM_AREAS)) chk_i (
  .i_core_clk         (i_core_clk),
  .i_rst_n            (i_rst_n),
  .i_mode             (i_mode),
  .i_addr             (i_addr),
  .i_wdata            (i_wdata),
  .i_wr               (i_wr),
  .i_rd               (i_rd),
  .o_rdata            (o_rdata),
  .o_area_8bit        (o_area_8bit),
  .o_area_states      (o_area_states),
  .o_area_waits       (o_area_waits),
  .o_area_wait_pin_en (o_area_wait_pin_en)
);

// File: verification/tb_ebac_top.sv
// Self-checking bench of the area configuration block.
// Assumes the mode strap is set while reset is held.
`timescale 1ns/10ps
module tb_ebac_top;
  logic        i_core_clk = 0;
  logic        i_rst_n = 0;
  logic [2:0]  i_mode = 3'h5;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr = 0;
  logic        i_rd = 0;
  wire  [7:0]  o_rdata, o_area_8bit, o_area_wait_pin_en;
  wire  [23:0] o_area_states;
  wire  [15:0] o_area_waits;
  wire  [3:0]  cyc0;
  int          error_cnt = 0;
  int          checks = 0;
  logic [7:0]  d;
  // Rows: address, write data, expected read back
  logic [31:0] rows [5] = '{32'hFED0A5A5, 32'hFED2E4E4, 32'hFED31B1B,
                            32'hFED10F0F, 32'hFED47700};
  ebac_top dut (
    .i_core_clk         (i_core_clk),
    .i_rst_n            (i_rst_n),
    .i_mode             (i_mode),
    .i_addr             (i_addr),
    .i_wdata            (i_wdata),
    .i_wr               (i_wr),
    .i_rd               (i_rd),
    .o_rdata            (o_rdata),
    .o_area_8bit        (o_area_8bit),
    .o_area_states      (o_area_states),
    .o_area_waits       (o_area_waits),
    .o_area_wait_pin_en (o_area_wait_pin_en)
  );
  ebac_mem_model mem (.i_states(o_area_states[2:0]),
    .i_waits(o_area_waits[1:0]), .o_cycles(cyc0));
  always #2.5 i_core_clk = ~i_core_clk;
  task chk(string n, logic [23:0] e, logic [23:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(logic [15:0] a, logic [7:0] v);
    @(posedge i_core_clk);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, v};
    @(posedge i_core_clk);
    i_wr <= 0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(logic [15:0] a);
    @(posedge i_core_clk);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_core_clk);
    i_rd <= 0;
    #1 d = o_rdata;
  endtask
  // Mode loads on the third edge after release; first request after it
  task rst(logic [2:0] m);
    @(posedge i_core_clk);
    {i_rst_n, i_mode} <= {1'h0, m};
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1;
    repeat (3) @(posedge i_core_clk);
  endtask
  task tally_and_finish;
    if (error_cnt == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    rst(3'h5);
    rd(16'hFED0);
    chk("width_rst", 8'hFF, d);
    rd(16'hFED1);
    chk("state_rst", 8'hFF, d);
    foreach (rows[i]) begin
      wr(rows[i][31:16], rows[i][15:8]);
      rd(rows[i][31:16]);
      chk("readback", rows[i][7:0], d);
    end
    chk("width", 8'hA5, o_area_8bit);
    chk("states", 24'h4926DB, o_area_states);
    chk("waits", 16'h001B, o_area_waits);
    chk("cycles", 4'h6, cyc0);
    chk("pin_en", 8'h0F, o_area_wait_pin_en);
    wr(16'hFED1, 8'hFF);
    rd(16'hFED1);
    chk("state_ff", 8'hFF, d);
    chk("states3", 24'h6DB6DB, o_area_states);
    chk("waits3", 16'hE41B, o_area_waits);
    rst(3'h4);
    rd(16'hFED0);
    chk("width_m4", 8'h00, d);
    rst(3'h7);
    rd(16'hFED0);
    chk("width_m7", 8'hFF, d);
    tally_and_finish();
  end
endmodule
